// ---- spi_flash_cmd.sv ----
// serial flash command engine: fast reads, dual reads, page write,
// sector and block clear; host owns select and serial clock
//
// How it works
// - fast read: opcode, 3 address bytes, dummy byte
// - read bytes leave on falling edges, address increments
// - read address wraps to zero past top
// - select high ends read, outputs released
// - reads ignored while a write cycle runs
// - dual output read returns two bits per clock
// - dual output read: eight dummy clocks, inputs ignored
// - dual io read: address and data two lanes
// - dual io read: four dummy clocks, inputs ignored
// - write commands need latch set by write enable
// - page write: opcode, address, data; only clears
// - page write wraps inside the addressed page
// - over 256 bytes: last 256 are kept
// - under 256 bytes: other page bytes untouched
// - select must rise on byte boundary, else dropped
// - select rise starts cycle; busy flag; latch clears
// - page write to protected page is refused
// - clear of protected area is refused
// - sector clear sets sector to ones, exact end
// - block clear sets block to ones, exact end
module spi_flash_cmd #(
	parameter int AW = 20
) (
	// system side
	input wire logic I_CLK,
	input wire logic I_RESET,
	input wire logic [2:0] I_BLOCK_PROTECT_BITS,
	output logic O_WRITE_IN_PROGRESS,
	output logic O_WRITE_ENABLE_LATCH,
	// serial link
	input wire logic I_SCK,
	input wire logic I_CHIP_ENABLE_N,
	input wire logic I_DATA_IN_IO_IN,
	input wire logic I_SERIAL_OUTPUT_IN,
	output logic O_DATA_IN_IO_OUT,
	output logic O_DATA_IN_IO_OE,
	output logic O_SERIAL_OUTPUT_OUT,
	output logic O_SERIAL_OUTPUT_OE
);
`include "flash_seq_map.svh"

	// ************************************************************
	// link side, clocked by the host's serial clock
	// ************************************************************
	logic first_q;
	flash_seq_pkg::link_st_t st_q, st_c, st_d;
	logic [4:0] cnt_q, cnt_c, cnt_d;
	logic [7:0] opc_q, opc_d, sh_q, sh_d, pidx_q, pidx_d;
	logic [23:0] addr_q, addr_d;
	logic got_q, got_d, pb_we, busy_s, dual, dio2;
	logic [255:0] mask_q;
	logic [7:0] rd_byte;
	logic [2:0] bit_hi;

	// the only flop set by select; the pin flops clear on select, state, count and got flag restart from it
	always_ff @(posedge I_SCK or posedge I_CHIP_ENABLE_N) begin
		if (I_CHIP_ENABLE_N)
			first_q <= 1'b1;
		else
			first_q <= 1'b0;
	end

	assign dual = (opc_q == `FS_OP_DUAL_OUT) || (opc_q == `FS_OP_DUAL_IO);
	assign dio2 = (opc_q == `FS_OP_DUAL_IO);

	always_comb begin
		st_c = first_q ? flash_seq_pkg::LK_CMD : st_q;
		cnt_c = first_q ? 5'h00 : cnt_q;
		got_d = first_q ? 1'b0 : got_q;
		st_d = st_c;
		cnt_d = cnt_c + 5'h01;
		opc_d = opc_q;
		sh_d = {sh_q[6:0], I_DATA_IN_IO_IN};
		addr_d = addr_q;
		pidx_d = pidx_q;
		pb_we = 1'b0;
		unique case (st_c)
		flash_seq_pkg::LK_CMD: begin
			if (cnt_c == `FS_CMD_LAST) begin
				opc_d = sh_d;
				cnt_d = 5'h00;
				if (busy_s)
					st_d = flash_seq_pkg::LK_IGN;
				else if (sh_d == `FS_OP_WRITE_ENABLE)
					st_d = flash_seq_pkg::LK_DONE;
				else if (sh_d == `FS_OP_FAST || sh_d == `FS_OP_DUAL_OUT ||
					sh_d == `FS_OP_DUAL_IO || sh_d == `FS_OP_PAGE_WRITE ||
					sh_d == `FS_OP_SMALL_CLEAR ||
					sh_d == `FS_OP_LARGE_CLEAR)
					st_d = flash_seq_pkg::LK_ADDR;
				else
					st_d = flash_seq_pkg::LK_IGN;
			end
		end
		flash_seq_pkg::LK_ADDR: begin
			if (dio2)
				addr_d = {addr_q[21:0], I_SERIAL_OUTPUT_IN,
					I_DATA_IN_IO_IN};
			else
				addr_d = {addr_q[22:0], I_DATA_IN_IO_IN};
			if (cnt_c == (dio2 ? `FS_ADDR_LAST_TWO : `FS_ADDR_LAST_ONE)) begin
				cnt_d = 5'h00;
				pidx_d = addr_d[7:0];
				if (opc_q == `FS_OP_PAGE_WRITE)
					st_d = flash_seq_pkg::LK_PIN;
				else if (opc_q == `FS_OP_SMALL_CLEAR ||
					opc_q == `FS_OP_LARGE_CLEAR)
					st_d = flash_seq_pkg::LK_DONE;
				else
					st_d = flash_seq_pkg::LK_DUMMY;
			end
		end
		flash_seq_pkg::LK_DUMMY: begin
			// input lanes are not looked at here
			if (cnt_c == (dio2 ? `FS_DUMMY_LAST_TWO
				: `FS_DUMMY_LAST_ONE)) begin
				cnt_d = 5'h00;
				st_d = flash_seq_pkg::LK_DOUT;
			end
		end
		flash_seq_pkg::LK_DOUT: begin
			if (cnt_c == (dual ? `FS_BYTE_LAST_TWO : `FS_BYTE_LAST_ONE)) begin
				cnt_d = 5'h00;
				// the concatenation keeps the sum at AW bits, so it wraps
				addr_d = {{(24-AW){1'b0}},
					addr_q[AW-1:0] + AW'(1)};
			end
		end
		flash_seq_pkg::LK_PIN: begin
			if (cnt_c == `FS_BYTE_LAST_ONE) begin
				cnt_d = 5'h00;
				pb_we = 1'b1;
				got_d = 1'b1;
				pidx_d = pidx_q + 8'h01;
			end
		end
		flash_seq_pkg::LK_DONE: begin
			// any clock past the last command bit spoils the command
			st_d = flash_seq_pkg::LK_IGN;
		end
		flash_seq_pkg::LK_IGN: begin
			cnt_d = cnt_c;
		end
		endcase
	end

	always_ff @(posedge I_SCK) begin
		st_q <= st_d;
		cnt_q <= cnt_d;
		got_q <= got_d;
	end

	always_ff @(posedge I_SCK) begin
		opc_q <= opc_d;
		sh_q <= sh_d;
		addr_q <= addr_d;
		pidx_q <= pidx_d;
	end

	// which bytes of the page buffer hold fresh data; cleared only as a
	// page write enters its data phase, so a frame sent while a program
	// cycle drains the buffer cannot wipe the marks under it
	always_ff @(posedge I_SCK) begin
		if (st_c == flash_seq_pkg::LK_ADDR &&
			st_d == flash_seq_pkg::LK_PIN)
			mask_q <= '0;
		else if (pb_we)
			mask_q[pidx_q] <= 1'b1;
	end

	// the read port looks one edge ahead, so the byte is ready
	// before the falling edge that starts shifting it
	assign bit_hi = dual ? 3'(3'h7 - {cnt_q[1:0], 1'b0})
		: 3'(3'h7 - cnt_q[2:0]);

	always_ff @(negedge I_SCK or posedge I_CHIP_ENABLE_N) begin
		if (I_CHIP_ENABLE_N) begin
			O_SERIAL_OUTPUT_OE <= 1'b0;
			O_DATA_IN_IO_OE <= 1'b0;
			O_SERIAL_OUTPUT_OUT <= 1'b0;
			O_DATA_IN_IO_OUT <= 1'b0;
		end else if (st_q == flash_seq_pkg::LK_DOUT) begin
			O_SERIAL_OUTPUT_OE <= 1'b1;
			O_DATA_IN_IO_OE <= dual;
			O_SERIAL_OUTPUT_OUT <= rd_byte[bit_hi];
			O_DATA_IN_IO_OUT <= rd_byte[3'(bit_hi - 3'h1)];
		end else begin
			O_SERIAL_OUTPUT_OE <= 1'b0;
			O_DATA_IN_IO_OE <= 1'b0;
		end
	end

	// ************************************************************
	// crossings and memories
	// ************************************************************
	logic busy_q, cs_s, cs_last_q, fe;
	logic [2:0] bp_s;
	flash_seq_pkg::frame_t fr;
	flash_seq_pkg::core_st_t core_q;
	logic [15:0] ecnt_q, span;
	logic [7:0] widx_q, pb_rd, mw_data;
	logic [23:0] tgt_q;
	logic [AW-1:0] mw_addr;
	logic wv_q, big_q, wel_q, mw_we, mw_and;

	flash_sync #(.W(1), .INIT(1'b0)) u_busy_sync (
		.i_clk(I_SCK),
		.i_rst(1'b0),
		.i_d(busy_q),
		.o_sync(busy_s)
	);

	flash_sync #(.W(1), .INIT(1'b1)) u_cs_sync (
		.i_clk(I_CLK),
		.i_rst(I_RESET),
		.i_d(I_CHIP_ENABLE_N),
		.o_sync(cs_s)
	);

	flash_sync #(.W(3), .INIT(3'h0)) u_bp_sync (
		.i_clk(I_CLK),
		.i_rst(I_RESET),
		.i_d(I_BLOCK_PROTECT_BITS),
		.o_sync(bp_s)
	);

	// page buffer: filled from the link, drained by the program cycle
	flash_byte_mem #(.AW(8)) u_page_buf (
		.i_wclk(I_SCK),
		.i_we(pb_we),
		.i_wand(1'b0),
		.i_waddr(pidx_q),
		.i_wdata(sh_d),
		.i_rclk(I_CLK),
		.i_raddr(ecnt_q[7:0]),
		.o_rdata(pb_rd)
	);

	// array: written by the core, read by the link
	flash_byte_mem #(.AW(AW)) u_array (
		.i_wclk(I_CLK),
		.i_we(mw_we),
		.i_wand(mw_and),
		.i_waddr(mw_addr),
		.i_wdata(mw_data),
		.i_rclk(I_SCK),
		.i_raddr(addr_d[AW-1:0]),
		.o_rdata(rd_byte)
	);

	// ************************************************************
	// core side: frame decisions and self-timed cycles
	// ************************************************************
	// the link clock stops once select is high, so its registers
	// hold still while this side samples them
	assign fr = {st_q, opc_q, addr_q, cnt_q, got_q};
	assign fe = cs_s && !cs_last_q;

	// protection: upper 2^(bp-1) blocks, saturating at all blocks
	function automatic logic prot_f(input logic [23:0] a,
		input logic [2:0] bp);
		int nb;
		int pc;
		nb = 1 << (AW - `FS_BLOCK_SHIFT);
		pc = (bp == 3'h0) ? 0 : (1 << (int'(bp) - 1));
		if (pc > nb)
			pc = nb;
		return (pc != 0) &&
			(int'(a[AW-1:`FS_BLOCK_SHIFT]) >= nb - pc);
	endfunction : prot_f

	logic prot, do_write_enable_cmd, do_prog, do_erase, is_clear;
	assign prot = prot_f(fr.addr, bp_s);
	assign is_clear = (fr.opc == `FS_OP_SMALL_CLEAR) ||
		(fr.opc == `FS_OP_LARGE_CLEAR);
	assign do_write_enable_cmd = fe && !busy_q && fr.st == flash_seq_pkg::LK_DONE &&
		fr.opc == `FS_OP_WRITE_ENABLE;
	assign do_prog = fe && !busy_q && wel_q && !prot &&
		fr.opc == `FS_OP_PAGE_WRITE && fr.got &&
		fr.st == flash_seq_pkg::LK_PIN && fr.cnt == 5'h00;
	assign do_erase = fe && !busy_q && wel_q && !prot &&
		is_clear && fr.st == flash_seq_pkg::LK_DONE;

	always_ff @(posedge I_CLK) begin
		if (I_RESET)
			cs_last_q <= 1'b1;
		else
			cs_last_q <= cs_s;
	end

	// latch drops as the cycle starts, well before it ends
	always_ff @(posedge I_CLK) begin
		if (I_RESET)
			wel_q <= 1'b0;
		else if (do_prog || do_erase)
			wel_q <= 1'b0;
		else if (do_write_enable_cmd)
			wel_q <= 1'b1;
	end

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			core_q <= flash_seq_pkg::CO_IDLE;
			busy_q <= 1'b0;
			ecnt_q <= 16'h0000;
			widx_q <= 8'h00;
			wv_q <= 1'b0;
			big_q <= 1'b0;
			tgt_q <= 24'h000000;
		end else begin
			unique case (core_q)
			flash_seq_pkg::CO_IDLE: begin
				ecnt_q <= 16'h0000;
				wv_q <= 1'b0;
				tgt_q <= fr.addr;
				big_q <= (fr.opc == `FS_OP_LARGE_CLEAR);
				if (do_prog) begin
					core_q <= flash_seq_pkg::CO_PROG;
					busy_q <= 1'b1;
				end else if (do_erase) begin
					core_q <= flash_seq_pkg::CO_ERASE;
					busy_q <= 1'b1;
				end
			end
			flash_seq_pkg::CO_PROG: begin
				// walk all 256 buffer slots; unmarked ones are skipped
				ecnt_q <= ecnt_q + 16'h0001;
				widx_q <= ecnt_q[7:0];
				wv_q <= 1'b1;
				if (wv_q && widx_q == `FS_PAGE_LAST) begin
					core_q <= flash_seq_pkg::CO_IDLE;
					busy_q <= 1'b0;
				end
			end
			flash_seq_pkg::CO_ERASE: begin
				ecnt_q <= ecnt_q + 16'h0001;
				if (ecnt_q == span) begin
					core_q <= flash_seq_pkg::CO_IDLE;
					busy_q <= 1'b0;
				end
			end
			default: begin
				core_q <= flash_seq_pkg::CO_IDLE;
				busy_q <= 1'b0;
			end
			endcase
		end
	end

	assign span = big_q ? `FS_BLOCK_SPAN : `FS_SECTOR_SPAN;

	always_comb begin
		mw_we = 1'b0;
		mw_and = 1'b0;
		mw_data = `FS_ERASED_BYTE;
		mw_addr = (tgt_q[AW-1:0] & ~AW'(span)) | AW'(ecnt_q);
		if (core_q == flash_seq_pkg::CO_PROG) begin
			mw_we = wv_q && mask_q[widx_q];
			mw_and = 1'b1;
			mw_data = pb_rd;
			mw_addr = {tgt_q[AW-1:8], widx_q};
		end else if (core_q == flash_seq_pkg::CO_ERASE) begin
			mw_we = 1'b1;
		end
	end

	assign O_WRITE_IN_PROGRESS = busy_q;
	assign O_WRITE_ENABLE_LATCH = wel_q;

	// ************************************************************
	// checks
	// ************************************************************
	property p_wel_set;
		@(posedge I_CLK) disable iff (I_RESET)
		do_write_enable_cmd |=> O_WRITE_ENABLE_LATCH;
	endproperty
	a_wel_set: assert property (p_wel_set)
		else $error("latch not set by write enable");

	property p_start_cause;
		@(posedge I_CLK) disable iff (I_RESET)
		$rose(busy_q) |-> $past(wel_q) && $past(fe);
	endproperty
	a_start_cause: assert property (p_start_cause)
		else $error("cycle started without latch or select rise");

	property p_wel_clr;
		@(posedge I_CLK) disable iff (I_RESET)
		$rose(busy_q) |-> !O_WRITE_ENABLE_LATCH && O_WRITE_IN_PROGRESS;
	endproperty
	a_wel_clr: assert property (p_wel_clr)
		else $error("latch still set after cycle start");

	property p_prot_page;
		@(posedge I_CLK) disable iff (I_RESET)
		fe && !busy_q && prot && fr.opc == `FS_OP_PAGE_WRITE |=> !busy_q;
	endproperty
	a_prot_page: assert property (p_prot_page)
		else $error("protected page was written");

	property p_prot_clear;
		@(posedge I_CLK) disable iff (I_RESET)
		fe && !busy_q && prot && is_clear |=> !busy_q;
	endproperty
	a_prot_clear: assert property (p_prot_clear)
		else $error("protected area was cleared");

	property p_boundary;
		@(posedge I_CLK) disable iff (I_RESET)
		fe && !busy_q && fr.opc == `FS_OP_PAGE_WRITE &&
			fr.cnt != 5'h00 |=> !busy_q;
	endproperty
	a_boundary: assert property (p_boundary)
		else $error("page write ran after a partial byte");

	property p_prog_len;
		@(posedge I_CLK) disable iff (I_RESET)
		$rose(busy_q) && core_q == flash_seq_pkg::CO_PROG
			|-> ##256 busy_q ##1 !busy_q;
	endproperty
	a_prog_len: assert property (p_prog_len)
		else $error("program cycle length wrong");

	property p_only_clear;
		@(posedge I_CLK) disable iff (I_RESET)
		mw_we && core_q == flash_seq_pkg::CO_PROG |-> mw_and;
	endproperty
	a_only_clear: assert property (p_only_clear)
		else $error("program may set bits");

	property p_erase_ones;
		@(posedge I_CLK) disable iff (I_RESET)
		core_q == flash_seq_pkg::CO_ERASE |-> mw_we && !mw_and &&
			mw_data == `FS_ERASED_BYTE;
	endproperty
	a_erase_ones: assert property (p_erase_ones)
		else $error("clear does not write ones");

	property p_wrap;
		@(posedge I_SCK) disable iff (I_CHIP_ENABLE_N)
		!first_q && st_q == flash_seq_pkg::LK_DOUT && cnt_d == 5'h00 &&
			addr_q[AW-1:0] == '1 |=> addr_q == 24'h000000;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("read address did not wrap");

	property p_busy_ignore;
		@(posedge I_SCK) disable iff (I_CHIP_ENABLE_N)
		st_c == flash_seq_pkg::LK_CMD && cnt_c == `FS_CMD_LAST && busy_s
			|=> st_q == flash_seq_pkg::LK_IGN;
	endproperty
	a_busy_ignore: assert property (p_busy_ignore)
		else $error("command taken during busy");

	property p_drive;
		@(posedge I_SCK) disable iff (I_CHIP_ENABLE_N)
		!first_q |-> O_SERIAL_OUTPUT_OE == (st_q == flash_seq_pkg::LK_DOUT)
			&& O_DATA_IN_IO_OE == (st_q == flash_seq_pkg::LK_DOUT && dual);
	endproperty
	a_drive: assert property (p_drive)
		else $error("pin drive outside data phase");

	c_dual_io: cover property (@(posedge I_SCK)
		st_q == flash_seq_pkg::LK_DOUT && dio2);
	c_prog: cover property (@(posedge I_CLK) do_prog);
	c_erase_big: cover property (@(posedge I_CLK) do_erase && is_clear &&
		fr.opc == `FS_OP_LARGE_CLEAR);
	c_wrap: cover property (@(posedge I_SCK) st_q == flash_seq_pkg::LK_DOUT
		&& addr_q[AW-1:0] == '1);
endmodule : spi_flash_cmd

// ---- flash_seq_map.svh ----
// constants for the serial flash command block: opcodes, phase
// lengths and erase spans; included by the design files only
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH
// opcodes
`define FS_OP_FAST 8'h0B
`define FS_OP_DUAL_OUT 8'h3B
`define FS_OP_DUAL_IO 8'hBB
`define FS_OP_PAGE_WRITE 8'h02
`define FS_OP_SMALL_CLEAR 8'h20
`define FS_OP_LARGE_CLEAR 8'hD8
`define FS_OP_WRITE_ENABLE 8'h06
// last clock index of each phase, counted from zero
`define FS_CMD_LAST 5'h07
`define FS_ADDR_LAST_ONE 5'h17
`define FS_ADDR_LAST_TWO 5'h0B
`define FS_DUMMY_LAST_ONE 5'h07
`define FS_DUMMY_LAST_TWO 5'h03
`define FS_BYTE_LAST_ONE 5'h07
`define FS_BYTE_LAST_TWO 5'h03
// erase spans, fill value, block shift and last page slot
`define FS_SECTOR_SPAN 16'h0FFF
`define FS_BLOCK_SPAN 16'hFFFF
`define FS_BLOCK_SHIFT 16
`define FS_ERASED_BYTE 8'hFF
`define FS_PAGE_LAST 8'hFF
`endif

// ---- flash_seq_pkg.sv ----
// types shared by the serial flash command block
// assumes nothing beyond a SystemVerilog compiler
package flash_seq_pkg;
	typedef enum logic [2:0] {
		LK_CMD, LK_ADDR, LK_DUMMY, LK_DOUT, LK_PIN, LK_DONE, LK_IGN
	} link_st_t;
	typedef enum logic [1:0] {CO_IDLE, CO_PROG, CO_ERASE} core_st_t;
	// snapshot of a finished frame, read after select rises
	typedef struct packed {
		link_st_t st;
		logic [7:0] opc;
		logic [23:0] addr;
		logic [4:0] cnt;
		logic got;
	} frame_t;
endpackage : flash_seq_pkg

// ---- flash_byte_mem.sv ----
// byte-wide memory, write port and registered read port on
// separate clocks; assumes the two ports never touch one word at once
module flash_byte_mem #(
	parameter int AW = 8
) (
	// write side
	input wire logic i_wclk,
	input wire logic i_we,
	input wire logic i_wand,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [7:0] i_wdata,
	// read side
	input wire logic i_rclk,
	input wire logic [AW-1:0] i_raddr,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [0:(1<<AW)-1];

	// and-mode only pulls bits low, as a flash cell does
	always_ff @(posedge i_wclk) begin
		if (i_we)
			mem[i_waddr] <= i_wand ? (mem[i_waddr] & i_wdata) : i_wdata;
	end

	always_ff @(posedge i_rclk) begin
		o_rdata <= mem[i_raddr];
	end
endmodule : flash_byte_mem

// ---- flash_sync.sv ----
// two-flop synchroniser for levels
// assumes each bit is an independent, slowly changing level
module flash_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_q;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_q <= INIT;
			o_sync <= INIT;
		end else begin
			meta_q <= i_d;
			o_sync <= meta_q;
		end
	end
endmodule : flash_sync

// ---- spi_host_model.sv ----
// serial host model: owns select and serial clock (mode 0, 12 ns
// period), moves bits on one or two lanes and resolves the shared pins
// assumes the flash command block's link pins are wired to its ports
module spi_host_model (
	// serial link
	output logic o_sck,
	output logic o_cs_n,
	output logic o_dio,
	output logic o_so,
	// device drive
	input wire logic i_dio_out,
	input wire logic i_dio_oe,
	input wire logic i_so_out,
	input wire logic i_so_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************************************
	// pin resolution
	// ****************************************************************
	logic h_dio = 1'b0;
	logic h_so = 1'b0;
	logic h_dio_oe = 1'b0;
	logic h_so_oe = 1'b0;
	logic flt = 1'b0;
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
	end
	// a released line wanders, so a stale bit cannot pass for data
	always #7 flt = ~flt;
	// two drivers at once give x, which no compare accepts
	assign o_dio = i_dio_oe ? (h_dio_oe ? 1'bx : i_dio_out)
		: (h_dio_oe ? h_dio : flt);
	assign o_so = i_so_oe ? (h_so_oe ? 1'bx : i_so_out)
		: (h_so_oe ? h_so : flt);
	// ****************************************************************
	// bit movers; data changes after falling edges only
	// ****************************************************************
	task automatic sel();
		#3 o_cs_n = 1'b0;
	endtask : sel
	// select rises after the last full clock, then stays high a while
	task automatic desel();
		#6 o_cs_n = 1'b1;
		h_dio_oe = 1'b0;
		h_so_oe = 1'b0;
		#120;
	endtask : desel
	task automatic clk1();
		#6 o_sck = 1'b1;
		#6 o_sck = 1'b0;
	endtask : clk1
	task automatic rel();
		h_dio_oe = 1'b0;
		h_so_oe = 1'b0;
	endtask : rel
	task automatic put1(input logic [7:0] b, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			h_dio_oe = 1'b1;
			h_dio = b[i];
			clk1();
		end
	endtask : put1
	task automatic put2(input logic [7:0] b);
		for (int i = 7; i > 0; i -= 2) begin
			h_dio_oe = 1'b1;
			h_so_oe = 1'b1;
			h_so = b[i];
			h_dio = b[i-1];
			clk1();
		end
	endtask : put2
	task automatic get1(output logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			#6 o_sck = 1'b1;
			b[i] = o_so;
			#6 o_sck = 1'b0;
		end
	endtask : get1
	task automatic get2(output logic [7:0] b);
		for (int i = 7; i > 0; i -= 2) begin
			#6 o_sck = 1'b1;
			b[i] = o_so;
			b[i-1] = o_dio;
			#6 o_sck = 1'b0;
		end
	endtask : get2
endmodule : spi_host_model

// ---- tb_top.sv ----
// testbench of the serial flash command block with a host model
// assumes flash_seq_pkg, spi_flash_cmd and spi_host_model are compiled
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************************************
	// environment
	// ****************************************************************
	// smallest legal array keeps erases and wrap reads short
	localparam int AW = 17;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] bp = 3'h0;
	logic write_in_progress;
	logic write_enable_latch;
	wire logic sck, cs_n, data_in_io, so, dio_out, dio_oe, so_out, so_oe;
	int n_mismatch = 0;
	int n_checks = 0;
	int c;
	logic [7:0] b;
	logic [7:0] shadow [0:(1<<AW)-1];
	logic [7:0] wq [$];
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
	n_mismatch++; $display("wrong value at %0t: got %h expected %h", \
	$time, got, exp); end end
	always #12.5 clk = ~clk;
	spi_flash_cmd #(.AW(AW)) DUT (.I_CLK(clk), .I_RESET(rst),
		.I_BLOCK_PROTECT_BITS(bp), .O_WRITE_IN_PROGRESS(write_in_progress),
		.O_WRITE_ENABLE_LATCH(write_enable_latch), .I_SCK(sck), .I_CHIP_ENABLE_N(cs_n),
		.I_DATA_IN_IO_IN(data_in_io), .I_SERIAL_OUTPUT_IN(so),
		.O_DATA_IN_IO_OUT(dio_out), .O_DATA_IN_IO_OE(dio_oe),
		.O_SERIAL_OUTPUT_OUT(so_out), .O_SERIAL_OUTPUT_OE(so_oe));
	spi_host_model HOST (.o_sck(sck), .o_cs_n(cs_n), .o_dio(data_in_io),
		.o_so(so), .i_dio_out(dio_out), .i_dio_oe(dio_oe),
		.i_so_out(so_out), .i_so_oe(so_oe));
	// ****************************************************************
	// expectations and frames
	// ****************************************************************
	function automatic logic [7:0] exp_at(input logic [23:0] a);
		return shadow[a[AW-1:0]];
	endfunction : exp_at
	// cycle count seen after the first status look, for a given span
	function automatic logic len_ok(input int n, input int span);
		return n > span - 60 && n <= span + 1;
	endfunction : len_ok
	// later bytes overwrite earlier ones in the page buffer
	task automatic model_prog(input logic [23:0] a);
		logic [7:0] pg [0:255];
		for (int j = 0; j < 256; j++) pg[j] = 8'hFF;
		foreach (wq[k]) pg[8'(a[7:0] + k)] = wq[k];
		for (int j = 0; j < 256; j++) shadow[{a[AW-1:8], 8'(j)}] &= pg[j];
	endtask : model_prog
	task automatic model_erase(input logic [23:0] a, input int span);
		for (int j = 0; j < span; j++) shadow[(a[AW-1:0] & ~(span - 1)) + j]
			= 8'hFF;
	endtask : model_erase
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic hdr(input logic [7:0] op, input logic [23:0] a);
		HOST.sel();
		HOST.put1(op, 8);
		for (int i = 2; i >= 0; i--) begin
			if (op == 8'hBB) HOST.put2(a[i*8+:8]);
			else HOST.put1(a[i*8+:8], 8);
		end
	endtask : hdr
	task automatic cmd(input logic [7:0] op, input logic [23:0] a,
		input int xb);
		if (op == 8'h06) begin
			HOST.sel();
			HOST.put1(op, 8);
		end else hdr(op, a);
		if (xb > 0) HOST.put1(8'($urandom), xb);
		HOST.desel();
	endtask : cmd
	task automatic prog(input logic [23:0] a, input int n, input int xb);
		wq.delete();
		repeat (n) wq.push_back(8'($urandom));
		hdr(8'h02, a);
		foreach (wq[k]) HOST.put1(wq[k], 8);
		if (xb > 0) HOST.put1(8'($urandom), xb);
		HOST.desel();
	endtask : prog
	task automatic post(input logic w, input logic l);
		cyc(4);
		`CHK(write_in_progress, w)
		`CHK(write_enable_latch, l)
	endtask : post
	task automatic waitdone();
		c = 0;
		while (write_in_progress === 1'b1 && c < 70000) begin
			@(negedge clk);
			c++;
		end
	endtask : waitdone
	task automatic rd(input logic [7:0] op, input logic [23:0] a,
		input int n);
		hdr(op, a);
		if (op == 8'h0B) HOST.put1(8'($urandom), 8);
		else begin
			HOST.rel();
			repeat (op == 8'h3B ? 8 : 4) HOST.clk1();
		end
		for (int i = 0; i < n; i++) begin
			if (op == 8'h0B) HOST.get1(b);
			else HOST.get2(b);
			`CHK(b, exp_at(a + 24'(i)))
		end
		HOST.desel();
		`CHK({dio_oe, so_oe}, 2'h0)
	endtask : rd
	// a read while a cycle runs must stay silent and leave it alone
	task automatic busy_rd();
		hdr(8'h0B, 24'h000000);
		HOST.put1(8'($urandom), 8);
		HOST.get1(b);
		`CHK({dio_oe, so_oe}, 2'h0)
		HOST.desel();
	endtask : busy_rd
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : summarize
	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		#2400000;
		n_mismatch++;
		summarize();
	end
	initial begin
		void'($urandom(32'h49FE0F8A));
		cyc(16);
		rst = 1'b0;
		cyc(6);
		`CHK({write_in_progress, write_enable_latch}, 2'h0)
		prog(24'h000000, 1, 0);
		post(1'b0, 1'b0);
		cmd(8'h06, 24'h0, 0);
		post(1'b0, 1'b1);
		cmd(8'h20, 24'h000000, 0);
		post(1'b1, 1'b0);
		busy_rd();
		waitdone();
		`CHK(len_ok(c, 4097), 1'b1)
		model_erase(24'h000000, 4096);
		cmd(8'h06, 24'h0, 0);
		cmd(8'h20, 24'h01F000, 0);
		post(1'b1, 1'b0);
		waitdone();
		model_erase(24'h01F000, 4096);
		// refused frames keep the latch
		cmd(8'h06, 24'h0, 0);
		prog(24'h000000, 1, 3);
		post(1'b0, 1'b1);
		cmd(8'h20, 24'h000000, 4);
		post(1'b0, 1'b1);
		cmd(8'hD8, 24'h000000, 8);
		post(1'b0, 1'b1);
		bp = 3'h1;
		cyc(4);
		cmd(8'h20, 24'h01F000, 0);
		post(1'b0, 1'b1);
		cmd(8'hD8, 24'h010000, 0);
		post(1'b0, 1'b1);
		prog(24'h01FF00, 4, 0);
		post(1'b0, 1'b1);
		bp = 3'h0;
		cyc(4);
		prog(24'h0000F0, 20, 0);
		post(1'b1, 1'b0);
		busy_rd();
		model_prog(24'h0000F0);
		waitdone();
		cmd(8'h06, 24'h0, 0);
		prog(24'h000100, 260, 0);
		post(1'b1, 1'b0);
		model_prog(24'h000100);
		waitdone();
		rd(8'h0B, 24'h01FFFE, 6);
		// select rises in mid-byte of the data phase
		hdr(8'h0B, 24'h000100);
		HOST.put1(8'($urandom), 8);
		repeat (3) HOST.clk1();
		HOST.desel();
		`CHK({dio_oe, so_oe}, 2'h0)
		rd(8'h3B, 24'h0000E0, 40);
		rd(8'hBB, 24'h0000FC, 10);
		cmd(8'h06, 24'h0, 0);
		cmd(8'hD8, 24'h000000, 0);
		post(1'b1, 1'b0);
		waitdone();
		`CHK(len_ok(c, 65537), 1'b1)
		model_erase(24'h000000, 65536);
		rd(8'h0B, 24'h0000FE, 4);
		summarize();
	end
endmodule : tb_top
